// file: verilog/vcc_control.v
`timescale 1ns/1ps
`include "vcc_map.vh"

module vcc_control
(
  input wire clock,
  input wire rst,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  output reg sfr_hit,
  input wire cmp_analog_in,
  output reg cmp_power_en,
  output reg [1:0] pos_hyst_sel,
  output reg [1:0] neg_hyst_sel,
  output reg [1:0] response_mode_sel,
  output reg [2:0] pos_input_sel,
  output reg [2:0] neg_input_sel,
  output reg pos_input_connect,
  output reg neg_input_connect,
  output reg cmp_latched_out,
  output reg cmp_raw_out,
  output reg cmp_reset_src,
  output reg rise_irq,
  output reg fall_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg cmp_enable_bit;
  reg rise_edge_flag;
  reg fall_edge_flag;
  reg rise_irq_enable;
  reg fall_irq_enable;
  reg sync_1;
  reg sync_2;
  reg cmp_state_bit;
  reg [7:0] next_rdata;
  reg next_hit;
  wire [1:0] next_flag;
  wire [1:0] flag_now;
  wire [1:0] flag_evt;
  wire [1:0] flag_wbit;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // True when the bus address selects the given register.
  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // Next value of one sticky edge flag.  A clearing write only takes
  // effect when no edge arrives in the same cycle, so no event is lost.
  function flag_update;
    input cur;
    input evt;
    input wr_hit;
    input wr_bit;
    begin
      flag_update = cur;
      if (wr_hit && !wr_bit)
        flag_update = 1'h0;
      if (evt)
        flag_update = 1'h1;
    end
  endfunction

  // Writes to an unmapped address fall through every decode and are lost.
  wire wr_ctl = sfr_wr && addr_is(sfr_addr, `VCC_ADDR_CONTROL);
  wire wr_md = sfr_wr && addr_is(sfr_addr, `VCC_ADDR_MODE);
  wire wr_mx = sfr_wr && addr_is(sfr_addr, `VCC_ADDR_INSEL);
  wire [7:0] md_w = sfr_wdata & `VCC_MD_WMASK;
  wire [7:0] mx_w = sfr_wdata & `VCC_MX_WMASK;
  // Edges are taken between the synchronized value and the state bit, so
  // they are seen only while enabled; disabling never makes a falling edge.
  wire rise_evt = cmp_enable_bit && sync_2 && !cmp_state_bit;
  wire fall_evt = cmp_enable_bit && !sync_2 && cmp_state_bit;

  // Decoder for an input select code; upper codes leave the input open.
  function sel_connects;
    input [2:0] code;
    begin
      sel_connects = !code[`VCC_MX_NONE_BIT];
    end
  endfunction

  // ----------------------------------------------------------------
  // Synchronizer
  // ----------------------------------------------------------------
  // The comparator result is asynchronous to the system clock.  Only the
  // second stage is read by logic, since the first may go metastable.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync_1 <= 1'h0;
      sync_2 <= 1'h0;
    end
    else
    begin
      sync_1 <= cmp_analog_in;
      sync_2 <= sync_1;
    end
  end

  // ----------------------------------------------------------------
  // Output state
  // ----------------------------------------------------------------
  // Every copy below is gated by the enable bit, which holds the pin
  // outputs low while the comparator is powered down.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cmp_state_bit <= 1'h0;
      cmp_latched_out <= 1'h0;
      cmp_raw_out <= 1'h0;
      cmp_reset_src <= 1'h0;
    end
    else
    begin
      cmp_state_bit <= cmp_enable_bit & sync_2;
      cmp_latched_out <= cmp_enable_bit & sync_2;
      cmp_reset_src <= cmp_enable_bit & sync_2;
      // The pass-through copy is retimed only because outputs come from
      // flip-flops; the analog block also drives the pin directly.
      cmp_raw_out <= cmp_enable_bit & cmp_analog_in;
    end
  end

  // ----------------------------------------------------------------
  // Edge flags
  // ----------------------------------------------------------------
  // Index 1 carries the rising-edge flag and index 0 the falling one, so
  // both flags share one update path and cannot drift apart in behaviour.
  assign flag_now = {rise_edge_flag, fall_edge_flag};
  assign flag_evt = {rise_evt, fall_evt};
  assign flag_wbit = {sfr_wdata[`VCC_CTL_RIF], sfr_wdata[`VCC_CTL_FIF]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_flag
      // Writing 1 leaves the flag alone; hardware never clears it.
      assign next_flag[gi] = flag_update(flag_now[gi], flag_evt[gi], wr_ctl,
                                         flag_wbit[gi]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Enabling the comparator or changing its hysteresis or response mode
  // can flag a false edge; software clears both flags shortly after.
  // The enable bit is not used to clear the flags either way.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cmp_enable_bit <= 1'h0;
      rise_edge_flag <= 1'h0;
      fall_edge_flag <= 1'h0;
      pos_hyst_sel <= 2'h0;
      neg_hyst_sel <= 2'h0;
      rise_irq_enable <= 1'h0;
      fall_irq_enable <= 1'h0;
      response_mode_sel <= `VCC_RST_MODE_SEL;
      pos_input_sel <= 3'h0;
      neg_input_sel <= 3'h0;
    end
    else
    begin
      rise_edge_flag <= next_flag[1];
      fall_edge_flag <= next_flag[0];
      if (wr_ctl)
      begin
        cmp_enable_bit <= sfr_wdata[`VCC_CTL_EN];
        pos_hyst_sel <= sfr_wdata[`VCC_CTL_HYP_HI:`VCC_CTL_HYP_LO];
        neg_hyst_sel <= sfr_wdata[`VCC_CTL_HYN_HI:`VCC_CTL_HYN_LO];
      end
      if (wr_md)
      begin
        rise_irq_enable <= md_w[`VCC_MD_RIE];
        fall_irq_enable <= md_w[`VCC_MD_FIE];
        response_mode_sel <= md_w[`VCC_MD_SEL_HI:`VCC_MD_SEL_LO];
      end
      if (wr_mx)
      begin
        pos_input_sel <= mx_w[`VCC_MX_P_HI:`VCC_MX_P_LO];
        neg_input_sel <= mx_w[`VCC_MX_N_HI:`VCC_MX_N_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Derived outputs
  // ----------------------------------------------------------------
  // Interrupt requests are levels that follow flag and enable one cycle
  // late; they drop only when software clears the flag or the enable.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cmp_power_en <= 1'h0;
      rise_irq <= 1'h0;
      fall_irq <= 1'h0;
      pos_input_connect <= 1'h0;
      neg_input_connect <= 1'h0;
    end
    else
    begin
      cmp_power_en <= cmp_enable_bit;
      rise_irq <= rise_edge_flag & rise_irq_enable;
      fall_irq <= fall_edge_flag & fall_irq_enable;
      pos_input_connect <= sel_connects(pos_input_sel);
      neg_input_connect <= sel_connects(neg_input_sel);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unused bits read as zero.  The state bit is read-only: the write path
  // above never touches it, whatever the control byte holds there.
  always @*
  begin
    next_rdata = 8'h00;
    next_hit = 1'h0;
    case (sfr_addr)
      `VCC_ADDR_CONTROL:
      begin
        next_hit = 1'h1;
        next_rdata = {cmp_enable_bit, cmp_state_bit, rise_edge_flag, fall_edge_flag,
                      pos_hyst_sel, neg_hyst_sel};
      end
      `VCC_ADDR_MODE:
      begin
        next_hit = 1'h1;
        next_rdata = {2'h0, rise_irq_enable, fall_irq_enable, 2'h0,
                      response_mode_sel};
      end
      `VCC_ADDR_INSEL:
      begin
        next_hit = 1'h1;
        next_rdata = {1'h0, neg_input_sel, 1'h0, pos_input_sel};
      end
      default:
      begin
        next_hit = 1'h0;
        next_rdata = 8'h00;
      end
    endcase
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'h0;
    end
    else
    begin
      sfr_rdata <= sfr_rd ? next_rdata : 8'h00;
      sfr_hit <= sfr_rd & next_hit;
    end
  end

endmodule

// file: verilog/vcc_map.vh
`ifndef VCC_MAP_VH
`define VCC_MAP_VH

// Register addresses on the special function register bus.
`define VCC_ADDR_CONTROL 8'h9B
`define VCC_ADDR_MODE 8'h9D
`define VCC_ADDR_INSEL 8'h9F

// Reset values.
`define VCC_RST_CONTROL 8'h00
`define VCC_RST_MODE 8'h02
`define VCC_RST_INSEL 8'h00
`define VCC_RST_MODE_SEL 2'h2

// Control register fields.
`define VCC_CTL_EN 7
`define VCC_CTL_OUT 6
`define VCC_CTL_RIF 5
`define VCC_CTL_FIF 4
`define VCC_CTL_HYP_HI 3
`define VCC_CTL_HYP_LO 2
`define VCC_CTL_HYN_HI 1
`define VCC_CTL_HYN_LO 0

// Mode register fields.
`define VCC_MD_RIE 5
`define VCC_MD_FIE 4
`define VCC_MD_SEL_HI 1
`define VCC_MD_SEL_LO 0
`define VCC_MD_WMASK 8'h33

// Input select register fields.
`define VCC_MX_N_HI 6
`define VCC_MX_N_LO 4
`define VCC_MX_P_HI 2
`define VCC_MX_P_LO 0
`define VCC_MX_WMASK 8'h77
`define VCC_MX_NONE_BIT 2

`endif

// file: verif/vcc_control_monitor.sv
`timescale 1ns/1ps
module vcc_monitor
(
  input logic clock,
  input logic rst,
  input logic sfr_rd,
  input logic [7:0] sfr_addr,
  input logic [7:0] sfr_rdata,
  input logic sfr_hit,
  input logic cmp_analog_in,
  input logic cmp_power_en,
  input logic [2:0] pos_input_sel,
  input logic pos_input_connect,
  input logic cmp_latched_out,
  input logic cmp_raw_out,
  input logic cmp_reset_src
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_on_hi;
    cmp_power_en && cmp_analog_in;
  endsequence
  sequence s_on_lo;
    cmp_power_en && !cmp_analog_in;
  endsequence
  a_off_low: assert property (!cmp_power_en && !$past(cmp_power_en) |->
    !cmp_latched_out && !cmp_raw_out) else $error("output high while off");
  a_src_copy: assert property (cmp_reset_src == cmp_latched_out)
    else $error("reset source differs");
  a_hi_state: assert property (s_on_hi [*4] |-> cmp_latched_out)
    else $error("latched output not high");
  a_lo_state: assert property (s_on_lo [*4] |-> !cmp_latched_out)
    else $error("latched output not low");
  a_sync_lag: assert property ($rose(cmp_latched_out) |-> $past(cmp_analog_in, 3))
    else $error("latched output too early");
  a_read_hit: assert property (sfr_rd && sfr_addr == 8'h9B |=> sfr_hit)
    else $error("control read missed");
  a_mode_zero: assert property (sfr_rd && sfr_addr == 8'h9D |=>
    sfr_rdata[7:6] == 2'h0 && sfr_rdata[3:2] == 2'h0) else $error("unused bits set");
  a_sel_connect: assert property (!$past(rst) |->
    pos_input_connect == ($past(pos_input_sel) < 3'h4)) else $error("connect wrong");
endmodule
bind vcc_control vcc_monitor u_vcc_monitor (.clock, .rst, .sfr_rd, .sfr_addr, .sfr_rdata,
  .sfr_hit, .cmp_analog_in, .cmp_power_en, .pos_input_sel, .pos_input_connect,
  .cmp_latched_out, .cmp_raw_out, .cmp_reset_src);

// file: verif/vcc_control_tb.sv
`timescale 1ns/1ps
module vcc_control_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic cmp_analog_in = 1'b0;
  wire [7:0] sfr_rdata;
  wire sfr_hit, cmp_power_en, pos_input_connect, neg_input_connect, cmp_latched_out;
  wire cmp_raw_out, cmp_reset_src, rise_irq, fall_irq;
  wire [1:0] pos_hyst_sel, neg_hyst_sel, response_mode_sel;
  wire [2:0] pos_input_sel, neg_input_sel;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'd71;
  logic [7:0] m_md = 8'h02;
  logic [7:0] m_mx = 8'h00;
  vcc_control u_vcc_control (.clock, .rst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
    .sfr_rdata, .sfr_hit, .cmp_analog_in, .cmp_power_en, .pos_hyst_sel, .neg_hyst_sel,
    .response_mode_sel, .pos_input_sel, .neg_input_sel, .pos_input_connect,
    .neg_input_connect, .cmp_latched_out, .cmp_raw_out, .cmp_reset_src, .rise_irq,
    .fall_irq);
  initial forever #10 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    if (a == 8'h9D)
      m_md = d & 8'h33;
    if (a == 8'h9F)
      m_mx = d & 8'h77;
    @(posedge clock);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1 sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge clock);
    #1 sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
    chk({7'h00, sfr_hit}, {7'h00, a != 8'h9C});
  endtask
  task automatic settle;
    repeat (5) @(posedge clock);
    #1;
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clock);
    err_total++;
    close_out;
  end
  initial
  begin
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    chk({6'h00, response_mode_sel}, 8'h02);
    rd(8'h9B, 8'h00);
    rd(8'h9D, 8'h02);
    rd(8'h9F, 8'h00);
    rd(8'h9C, 8'h00);
    cmp_analog_in = 1'b1;
    repeat (8)
    begin
      seed = xs(seed);
      wr(8'h9D, seed[7:0]);
      wr(8'h9F, seed[15:8]);
      wr(8'h9B, seed[23:16] & 8'h0F);
      rd(8'h9D, m_md);
      rd(8'h9F, m_mx);
      rd(8'h9B, seed[23:16] & 8'h0F);
      chk({pos_hyst_sel, neg_hyst_sel, response_mode_sel, 2'h0}, {seed[19:16], seed[1:0], 2'h0});
      chk({pos_input_connect, neg_input_connect, pos_input_sel, neg_input_sel},
        {!seed[10], !seed[14], seed[10:8], seed[14:12]});
      chk({cmp_latched_out, cmp_raw_out, cmp_power_en, 5'h00}, 8'h00);
    end
    wr(8'h9D, 8'h30);
    cmp_analog_in = 1'b0;
    wr(8'h9B, 8'h80);
    settle();
    wr(8'h9B, 8'h80);
    rd(8'h9B, 8'h80);
    cmp_analog_in = 1'b1;
    @(posedge clock);
    #1 chk({cmp_raw_out, cmp_latched_out, 6'h00}, 8'h80);
    settle();
    rd(8'h9B, 8'hE0);
    chk({rise_irq, fall_irq, cmp_latched_out, cmp_raw_out, cmp_reset_src, 3'h0}, 8'hB8);
    cmp_analog_in = 1'b0;
    settle();
    rd(8'h9B, 8'hB0);
    chk({rise_irq, fall_irq, cmp_latched_out, cmp_raw_out, cmp_reset_src, 3'h0}, 8'hC0);
    wr(8'h9B, 8'hB0);
    rd(8'h9B, 8'hB0);
    wr(8'h9D, 8'h00);
    settle();
    chk({rise_irq, fall_irq, 6'h00}, 8'h00);
    wr(8'h9B, 8'h80);
    rd(8'h9B, 8'h80);
    cmp_analog_in = 1'b1;
    @(posedge clock);
    wr(8'h9B, 8'h80);
    rd(8'h9B, 8'hE0);
    wr(8'h9B, 8'h00);
    rd(8'h9B, 8'h00);
    close_out;
  end
endmodule
